// >>> src/skx_top.sv
// Summary of operation
// - Response sets one offered bit per class
// - Unsupported class answers all zeros
// - Public-key and hash: only bit 0
// - Encryption bit 3 AES counter, 24 bytes
// - Encryption bit 2 AES chaining, 16 bytes
// - DES 56 and 40 bits, 8 bytes
// - Nonce class: only bit 0, eight bytes
// - Context version bit sent as zero
// - Stream kind picks MAC or VPI/VCI
// - Context: 24-bit stream, 6-bit key index
// - Connection identifier must be zero
// - Flag byte: first, cookie, bump, slot
// - Slot flag chooses session key updated
// - Bump flag advances clone counter
// - New cookie: regenerate, clear clone counter
// - Reserved byte, nonce, modulus, generator, public
// - Field lengths come from negotiated choices
// - Minimum support: DH512, SHA1, DES40, nonce8
// - VPI eight bits then VCI sixteen
// - Own unicast stream: identifier, index zero
module skx_top
  import skx_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             fld_valid,
  output logic      [2:0]  fld_code,
  output logic      [7:0]  fld_byte,
  output logic             fld_last,
  output logic             key_update,
  output logic             key_slot,
  output logic             cookie_regen,
  output logic             ignore_auth,
  output logic      [7:0]  clone_count
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [3:0]  ctrl;
  logic [31:0] offer;
  logic [31:0] ctxt;
  logic [31:0] resp;
  logic [31:0] pick_word;
  logic [31:0] support_word;
  logic        offer_dirty;
  logic        neg_valid;
  logic [7:0]  p_ns;
  logic [7:0]  p_pka;
  logic [7:0]  p_ea;
  logic [7:0]  p_ha;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        ap_take;
  logic        wr_take;
  logic [31:0] rd_mux;
  logic        conn_err;
  logic        rsvd_err;
  logic        msg_done;
  logic [7:0]  flags;
  skx_state_t  state;
  skx_state_t  next_state;
  logic [7:0]  cnt;
  logic        take;
  logic        field_end;
  logic        msg_end;
  logic [31:0] resp_ctxt;
  logic [31:0] info;
  logic        unicast_ctx;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Encryption parameter size of the chosen bit
  function automatic logic [7:0] enc_size(input logic [7:0] choice);
    logic [7:0] s;
    s = 8'h00;
    if (choice[BIT_AES_COUNTER]) begin
      s = P_AESCTR;
    end else if (choice[BIT_AES_CHAINING]) begin
      s = P_AESCBC;
    end else if (choice[BIT_DES56_CHOICE] || choice[BIT_DES40_CHOICE]) begin
      s = P_DES;
    end
    return s;
  endfunction

  // Length of the field that a parser state stands in
  function automatic logic [7:0] field_len(input skx_state_t st, input logic [7:0] ns, input logic [7:0] pk);
    logic [7:0] l;
    case (st)
      ST_CONN:  l = CONN_BYTES;
      ST_FLAGS: l = 8'h01;
      ST_RSVD:  l = 8'h01;
      ST_NONCE: l = ns;
      default:  l = pk;
    endcase
    return l;
  endfunction

  // ****************************************************************
  // Class selection
  // ****************************************************************
  // Mandatory choices are always supported; the rest follow control bits
  always_comb begin
    support_word = 32'h0000_0000;
    support_word[CLS_PK*8+BIT_DH512_CHOICE]         = 1'b1;
    support_word[CLS_HASH*8+BIT_HMAC_SHA1_CHOICE]   = 1'b1;
    support_word[CLS_NONCE*8+BIT_NONCE8_CHOICE]     = 1'b1;
    support_word[CLS_ENC*8+BIT_DES40_CHOICE]        = 1'b1;
    support_word[CLS_ENC*8+BIT_DES56_CHOICE]        = ctrl[CTRL_DES56_EN];
    support_word[CLS_ENC*8+BIT_AES_CHAINING]        = ctrl[CTRL_AESCBC_EN];
    support_word[CLS_ENC*8+BIT_AES_COUNTER]         = ctrl[CTRL_AESCTR_EN];
  end

  // One picker per class; reserved offer bits never reach it
  for (genvar g = 0; g < 4; g++) begin : g_cls
    skx_class_pick u_pick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .offer   (offer[g*8 +: 8]),
      .support (support_word[g*8 +: 8]),
      .pick    (pick_word[g*8 +: 8])
    );
  end

  // Response latched one cycle after any offer write, even mid-message; sizes change only then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp <= 32'h0000_0000;
    end else if (ce && offer_dirty) begin
      resp <= pick_word;
    end
  end

  // Negotiated sizes follow the latched choices only, never the message
  assign neg_valid = (resp[CLS_PK*8 +: 8] != 8'h00) && (resp[CLS_NONCE*8 +: 8] != 8'h00)
                   && (resp[CLS_HASH*8 +: 8] != 8'h00) && (resp[CLS_ENC*8 +: 8] != 8'h00);
  assign p_pka = resp[CLS_PK*8+BIT_DH512_CHOICE] ? P_DH512 : 8'h00;
  assign p_ns  = resp[CLS_NONCE*8+BIT_NONCE8_CHOICE] ? P_NONCE8 : 8'h00;
  assign p_ha  = resp[CLS_HASH*8+BIT_HMAC_SHA1_CHOICE] ? P_SHA1 : 8'h00;
  assign p_ea  = enc_size(resp[CLS_ENC*8 +: 8]);

  // ****************************************************************
  // Context word
  // ****************************************************************
  // Version bit forced low on the way back out
  always_comb begin
    resp_ctxt              = ctxt;
    resp_ctxt[CTX_VERSION] = 1'b0;
  end

  // Stream identity view: VPI over VCI, or the low MAC address bits
  assign info = ctxt[CTX_KIND] ? {8'h00, ctxt[CTX_ID_HI:CTX_ID_LO]}
                               : {9'h000, ctxt[CTX_ID_LO+22:CTX_ID_LO]};
  assign unicast_ctx = !ctxt[CTX_KIND] && (ctxt[CTX_ID_HI:0] == 30'h0000_0000);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; clock enable low stretches the data phase instead
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign ap_take   = ce && hsel && hready && htrans[1];
  assign wr_take   = ce && dp_write;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (ce) begin
      dp_write <= ap_take && hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // Read mux, sampled in the address phase so read data comes from a flop
  always_comb begin
    case (haddr[7:0])
      OFS_CTRL:      rd_mux = {28'h000_0000, ctrl};
      OFS_OFFER:     rd_mux = offer;
      OFS_CTXT:      rd_mux = ctxt;
      OFS_RESP:      rd_mux = resp;
      OFS_RESP_CTXT: rd_mux = resp_ctxt;
      OFS_STATUS:    rd_mux = {p_pka, p_ha, p_ea, msg_done, unicast_ctx, key_slot, ignore_auth,
                               rsvd_err, conn_err, (state != ST_CONN), neg_valid};
      OFS_CLONE:     rd_mux = {24'h00_0000, clone_count};
      OFS_INFO:      rd_mux = info;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Software-written registers; reserved offer bits are dropped on write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl        <= CTRL_RST;
      offer       <= 32'h0000_0000;
      ctxt        <= 32'h0000_0000;
      offer_dirty <= 1'b0;
    end else if (ce) begin
      offer_dirty <= wr_take && (dp_addr == OFS_OFFER);
      if (wr_take && dp_addr == OFS_CTRL) begin
        ctrl <= hwdata[3:0];
      end
      if (wr_take && dp_addr == OFS_OFFER) begin
        offer <= hwdata & {PK_VALID_MASK, HASH_VALID_MASK, ENC_VALID_MASK, NONCE_VALID_MASK};
      end
      if (wr_take && dp_addr == OFS_CTXT) begin
        ctxt <= hwdata;
      end
    end
  end

  // ****************************************************************
  // Main key exchange parser
  // ****************************************************************
  // Bytes are refused until a complete negotiation exists
  assign rx_ready  = ce && ctrl[CTRL_PARSE_EN] && neg_valid;
  assign take      = rx_valid && rx_ready;
  assign field_end = take && (cnt == field_len(state, p_ns, p_pka) - 8'h01);
  assign msg_end   = field_end && (state == ST_PUBX);

  // Fields follow one another in fixed order
  always_comb begin
    case (state)
      ST_CONN:  next_state = ST_FLAGS;
      ST_FLAGS: next_state = ST_RSVD;
      ST_RSVD:  next_state = ST_NONCE;
      ST_NONCE: next_state = ST_MOD;
      ST_MOD:   next_state = ST_GEN;
      ST_GEN:   next_state = ST_PUBX;
      default:  next_state = ST_CONN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_CONN;
      cnt   <= 8'h00;
    end else if (take) begin
      if (field_end) begin
        state <= next_state;
        cnt   <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // Each byte leaves tagged with its field; MSB-first order is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fld_valid <= 1'b0;
      fld_code  <= 3'b000;
      fld_byte  <= 8'h00;
      fld_last  <= 1'b0;
    end else if (ce) begin
      fld_valid <= take;
      if (take) begin
        fld_code <= state;
        fld_byte <= rx_data;
        fld_last <= field_end;
      end
    end
  end

  // Flag byte holds its effect until the message completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= 8'h00;
    end else if (take && state == ST_FLAGS) begin
      flags <= rx_data;
    end
  end

  // Error flags: set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conn_err <= 1'b0;
      rsvd_err <= 1'b0;
      msg_done <= 1'b0;
    end else if (ce) begin
      if (take && state == ST_CONN && rx_data != 8'h00) begin
        conn_err <= 1'b1;
      end else if (wr_take && dp_addr == OFS_STATUS && hwdata[2]) begin
        conn_err <= 1'b0;
      end
      if (take && ((state == ST_FLAGS && (rx_data & FLG_RSVD_MASK) != 8'h00)
                   || (state == ST_RSVD && rx_data != 8'h00))) begin
        rsvd_err <= 1'b1;
      end else if (wr_take && dp_addr == OFS_STATUS && hwdata[3]) begin
        rsvd_err <= 1'b0;
      end
      if (msg_end) begin
        msg_done <= 1'b1;
      end else if (wr_take && dp_addr == OFS_STATUS && hwdata[7]) begin
        msg_done <= 1'b0;
      end
    end
  end

  // Completion actions; a new cookie clears the counter and overrides a bump
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_update   <= 1'b0;
      cookie_regen <= 1'b0;
      key_slot     <= 1'b0;
      ignore_auth  <= 1'b0;
      clone_count  <= 8'h00;
    end else if (ce) begin
      key_update   <= msg_end;
      cookie_regen <= msg_end && flags[FLG_COOKIE];
      if (msg_end) begin
        key_slot    <= flags[FLG_SLOT];
        ignore_auth <= flags[FLG_FIRST];
        if (flags[FLG_COOKIE]) begin
          clone_count <= 8'h00;
        end else if (flags[FLG_BUMP]) begin
          clone_count <= clone_count + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RESP_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
    (resp & ~{PK_VALID_MASK, HASH_VALID_MASK, ENC_VALID_MASK, NONCE_VALID_MASK}) == 32'h0)
    else $error("reserved response bit set");
  AST_MIN_SUPPORT: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && offer_dirty && offer[CLS_ENC*8] && !ctrl[CTRL_DES56_EN] && !ctrl[CTRL_AESCBC_EN]
    && !ctrl[CTRL_AESCTR_EN] |=> resp[CLS_ENC*8 +: 8] == 8'h01) else $error("40-bit DES not chosen");
  AST_VERSION_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    !resp_ctxt[CTX_VERSION]) else $error("version bit not zero");
  AST_NONCE_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    take && state == ST_NONCE |-> cnt < P_NONCE8) else $error("nonce overran eight bytes");
  AST_MOD_END: assert property (@(posedge hclk) disable iff (!hresetn)
    take && state == ST_MOD && cnt == 8'h3F |=> state == ST_GEN) else $error("modulus length wrong");
  AST_CONN_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
    take && state == ST_CONN && rx_data != 8'h00 |=> conn_err) else $error("nonzero id missed");
  AST_CLONE_BUMP: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && msg_end && flags[FLG_BUMP] && !flags[FLG_COOKIE] |=> clone_count == $past(clone_count) + 8'h01)
    else $error("clone counter not advanced");
  AST_CLONE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && msg_end && flags[FLG_COOKIE] |=> clone_count == 8'h00 && cookie_regen && key_update)
    else $error("cookie refresh incomplete");
  AST_KEY_SLOT: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && msg_end |=> key_update && key_slot == $past(flags[FLG_SLOT])) else $error("wrong key slot");

  COV_MSG_DONE: cover property (@(posedge hclk) disable iff (!hresetn) msg_end);
  COV_NEW_COOKIE: cover property (@(posedge hclk) disable iff (!hresetn) cookie_regen);
  COV_ZERO_CLASS: cover property (@(posedge hclk) disable iff (!hresetn) offer_dirty && !neg_valid);
endmodule

// >>> src/skx_pkg.sv
package skx_pkg;
  // ****************************************************************
  // Register map (byte addresses on the bus)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_OFFER     = 8'h04;
  localparam logic [7:0] OFS_CTXT      = 8'h08;
  localparam logic [7:0] OFS_RESP      = 8'h0C;
  localparam logic [7:0] OFS_RESP_CTXT = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_CLONE     = 8'h18;
  localparam logic [7:0] OFS_INFO      = 8'h1C;

  // ****************************************************************
  // Control register fields and reset values
  // ****************************************************************
  localparam int CTRL_PARSE_EN   = 0;
  localparam int CTRL_DES56_EN   = 1;
  localparam int CTRL_AESCBC_EN  = 2;
  localparam int CTRL_AESCTR_EN  = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ****************************************************************
  // Class bytes inside the offer and response words
  // ****************************************************************
  localparam int CLS_PK    = 3;  // Byte lane 3 of the word
  localparam int CLS_HASH  = 2;
  localparam int CLS_ENC   = 1;
  localparam int CLS_NONCE = 0;
  localparam int BIT_DH512_CHOICE     = 0;
  localparam int BIT_HMAC_SHA1_CHOICE = 0;
  localparam int BIT_AES_COUNTER      = 3;
  localparam int BIT_AES_CHAINING     = 2;
  localparam int BIT_DES56_CHOICE     = 1;
  localparam int BIT_DES40_CHOICE     = 0;
  localparam int BIT_NONCE8_CHOICE    = 0;
  localparam logic [7:0] PK_VALID_MASK    = 8'h01;
  localparam logic [7:0] HASH_VALID_MASK  = 8'h01;
  localparam logic [7:0] ENC_VALID_MASK   = 8'h0F;
  localparam logic [7:0] NONCE_VALID_MASK = 8'h01;

  // ****************************************************************
  // Parameter byte counts of each choice
  // ****************************************************************
  localparam logic [7:0] P_DH512  = 8'h40;  // 64 bytes
  localparam logic [7:0] P_SHA1   = 8'h14;  // 20 bytes
  localparam logic [7:0] P_AESCTR = 8'h18;  // 24 bytes
  localparam logic [7:0] P_AESCBC = 8'h10;  // 16 bytes
  localparam logic [7:0] P_DES    = 8'h08;  // 8 bytes
  localparam logic [7:0] P_NONCE8 = 8'h08;  // 8 bytes
  localparam logic [7:0] CONN_BYTES = 8'h04;

  // ****************************************************************
  // Context word fields
  // ****************************************************************
  localparam int CTX_VERSION = 31;
  localparam int CTX_KIND    = 30;
  localparam int CTX_ID_HI   = 29;
  localparam int CTX_ID_LO   = 6;
  localparam int CTX_KEY_HI  = 5;

  // ****************************************************************
  // Flag byte of the main key exchange
  // ****************************************************************
  localparam int FLG_FIRST   = 3;
  localparam int FLG_COOKIE  = 2;
  localparam int FLG_BUMP    = 1;
  localparam int FLG_SLOT    = 0;
  localparam logic [7:0] FLG_RSVD_MASK = 8'hF0;

  // ****************************************************************
  // Parser states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CONN  = 3'b000,
    ST_FLAGS = 3'b001,
    ST_RSVD  = 3'b010,
    ST_NONCE = 3'b011,
    ST_MOD   = 3'b100,
    ST_GEN   = 3'b101,
    ST_PUBX  = 3'b110
  } skx_state_t;
endpackage

// >>> src/skx_class_pick.sv
module skx_class_pick
  import skx_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] offer,
  input  wire logic [7:0] support,
  output logic      [7:0] pick
);
  logic [7:0] usable;

  // Only offered and supported bits count; reserved bits are never in support
  assign usable = offer & support;

  // Highest usable bit wins, so the strongest cipher is preferred
  always_comb begin
    pick = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (usable[i]) begin
        pick = 8'h01 << i;
      end
    end
  end

  AST_PICK_ONEHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot0(pick) && ((pick & ~usable) == 8'h00)) else $error("pick not one offered bit");
  AST_PICK_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (usable == 8'h00) |-> (pick == 8'h00)) else $error("pick set with nothing usable");
endmodule

// >>> bench/skx_ctrl_model.sv
module skx_ctrl_model
  import skx_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic       bad_conn,
  input  wire logic [7:0] flags,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Main key exchange sender
  // ****************************************************************
  localparam int MSG_LEN = 6 + P_NONCE8 + 3 * P_DH512;
  int idx;

  // Byte of the message at position i, fields packed in order
  function automatic logic [7:0] byte_at(input int i);
    if (i < 4) return (bad_conn && i == 0) ? 8'h80 : 8'h00;
    if (i == 4) return flags;
    if (i == 5) return 8'h00;
    return 8'(i) ^ 8'h5A;
  endfunction

  // Holds each byte until taken; an idle line toggles so no stale value passes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'hA5;
      idx      <= 0;
      busy     <= 1'b0;
    end else if (start && !busy) begin
      busy     <= 1'b1;
      idx      <= 0;
      rx_valid <= 1'b1;
      rx_data  <= byte_at(0);
    end else if (busy && rx_valid && rx_ready) begin
      if (idx == MSG_LEN - 1) begin
        busy     <= 1'b0;
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end else if (slow) begin
        rx_valid <= 1'b0; // Slow sender leaves a gap after every byte
        rx_data  <= ~rx_data;
        idx      <= idx + 1;
      end else begin
        idx      <= idx + 1;
        rx_data  <= byte_at(idx + 1);
      end
    end else if (busy && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_data  <= byte_at(idx);
    end else if (!rx_valid) begin
      rx_data  <= ~rx_data;
    end
  end
endmodule

// >>> bench/security_signon_key_exchange_test.sv
module security_signon_key_exchange_test
  import skx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N0      = 6 + P_NONCE8;
  localparam int MSG_LEN = N0 + 3 * P_DH512;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, pslow = 1'b0, pbad = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, fld_code;
  logic [7:0]  pflags = 8'h00, rx_data, fld_byte, clone_count, last_taken;
  logic        hready, hresp, rx_valid, rx_ready, fld_valid, fld_last, key_update, key_slot, cookie_regen;
  logic        ignore_auth, mbusy;
  int          miscompares = 0, tests_run = 0, cyc = 0, nbytes = 0, nkeys = 0, ncook = 0;

  // ****************************************************************
  // Device and controller model
  // ****************************************************************
  skx_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .fld_valid(fld_valid),
    .fld_code(fld_code), .fld_byte(fld_byte), .fld_last(fld_last), .key_update(key_update),
    .key_slot(key_slot), .cookie_regen(cookie_regen), .ignore_auth(ignore_auth), .clone_count(clone_count));
  skx_ctrl_model ctrl_u (.hclk(hclk), .hresetn(hresetn), .start(start), .slow(pslow), .bad_conn(pbad),
    .flags(pflags), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .busy(mbusy));

  // Clock at 125 MHz
  always #4 hclk = ~hclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One single AHB-Lite transfer; read data is taken at the end of the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    ahb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask

  // Field code and field end expected at byte position i
  function automatic logic [2:0] code_of(input int i);
    return 3'((i < 4) ? 0 : (i < 6) ? i - 3 : (i < N0) ? 3 : 4 + (i - N0) / P_DH512);
  endfunction
  function automatic logic last_of(input int i);
    return i == 3 || i == 4 || i == 5 || i == N0 - 1 || (i >= N0 && (i - N0) % P_DH512 == P_DH512 - 1);
  endfunction

  // Byte link monitor and run-time ceiling; a stall would otherwise hang the run
  always @(posedge hclk) begin
    if (fld_valid === 1'b1) begin
      chk("fld_byte", 32'(last_taken), 32'(fld_byte));
      chk("fld_code", 32'(code_of(nbytes)), 32'(fld_code));
      chk("fld_last", 32'(last_of(nbytes)), 32'(fld_last));
      nbytes++;
    end
    if (key_update === 1'b1) nkeys++;
    if (cookie_regen === 1'b1) ncook++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) last_taken = rx_data;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("clone", OFS_CLONE, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    chk("rx_ready", 32'h0, 32'(rx_ready));
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  // Offers against support sets, the last two leaving a class with no usable choice (one unsupported, one not offered)
  task automatic t_nego();
    logic [3:0]  sup [6] = '{4'h1, 4'hF, 4'h7, 4'h3, 4'h3, 4'h1};
    logic [31:0] ofr [6] = '{32'hFFFFFFFF, 32'h01010F01, 32'h01010601, 32'h01010301, 32'h01010401, 32'h00010101};
    logic [31:0] exr [6] = '{32'h01010101, 32'h01010801, 32'h01010401, 32'h01010201, 32'h01010001, 32'h00010101};
    logic [7:0]  esz [6] = '{P_DES, P_AESCTR, P_AESCBC, P_DES, 8'h00, 8'h00};
    logic        neg;
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, OFS_CTRL, {28'h0, sup[i]});
      ahb(1'b1, OFS_OFFER, ofr[i]);
      rchk("resp", OFS_RESP, exr[i]);
      neg = (exr[i][31:24] != 8'h0) && (exr[i][23:16] != 8'h0) && (exr[i][15:8] != 8'h0) && (exr[i][7:0] != 8'h0);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("negotiated", 32'(neg), 32'(rd[0]));
      if (neg) chk("sizes", {8'h0, P_DH512, P_SHA1, esz[i]}, {8'h0, rd[31:8]});
      chk("rx_ready", 32'(neg), 32'(rx_ready));
    end
  endtask

  task automatic t_ctx();
    ahb(1'b1, OFS_CTXT, {2'b11, 24'hABCDEF, 6'h2A});
    rchk("resp_ctxt", OFS_RESP_CTXT, {2'b01, 24'hABCDEF, 6'h2A});
    rchk("info_path", OFS_INFO, {8'h0, 24'hABCDEF});
    ahb(1'b1, OFS_CTXT, {2'b00, 24'h812345, 6'h00});
    rchk("info_mac", OFS_INFO, {9'h0, 23'h012345});
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("unicast", 32'h0, 32'(rd[6]));
    ahb(1'b1, OFS_CTXT, 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("unicast", 32'h1, 32'(rd[6]));
  endtask

  task automatic send_msg(input logic [7:0] f, input logic s, input logic b, input logic [7:0] exc);
    int k;
    int c;
    k = nkeys;
    c = ncook;
    nbytes = 0;
    @(posedge hclk);
    pflags <= f;
    pslow  <= s;
    pbad   <= b;
    start  <= 1'b1;
    @(posedge hclk);
    start  <= 1'b0;
    do @(posedge hclk); while (mbusy !== 1'b0);
    repeat (3) @(posedge hclk);
    chk("bytes", MSG_LEN, nbytes);
    chk("key_update", k + 1, nkeys);
    chk("cookie_regen", c + f[2], ncook);
    chk("key_slot", 32'(f[0]), 32'(key_slot));
    chk("ignore_auth", 32'(f[3]), 32'(ignore_auth));
    chk("clone", 32'(exc), 32'(clone_count));
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'({1'b1, f[7:4] != 4'h0, b}), 32'({rd[7], rd[3], rd[2]}));
    ahb(1'b1, OFS_STATUS, 32'h8C);
  endtask

  // Minimum support negotiated, then four messages in turn with status checks between, one slow, one faulty
  task automatic t_msg();
    ahb(1'b1, OFS_CTRL, 32'h1);
    ahb(1'b1, OFS_OFFER, 32'hFFFFFFFF);
    send_msg(8'h0A, 1'b0, 1'b0, 8'h01);
    send_msg(8'h03, 1'b1, 1'b0, 8'h02);
    send_msg(8'h06, 1'b0, 1'b0, 8'h00);
    send_msg(8'h12, 1'b0, 1'b1, 8'h01);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_nego();
    t_ctx();
    t_msg();
    close_out();
  end
endmodule
